// File: bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  input wire logic ack,
  output logic sel,
  output logic write,
  output logic wide,
  output timer_pkg::chan_t chan,
  output logic reg_sel,
  output logic [15:0] wdata
);
  import timer_pkg::*;
  initial begin
    sel = 1'b0;
    write = 1'b0;
    wide = 1'b1;
    chan = '0;
    reg_sel = 1'b0;
    wdata = '0;
  end
  // A request stands one cycle; the answer is taken a cycle later once settled.
  // Released write data is inverted so a stale value can never pass for a fresh one.
  task automatic access(input logic w, input logic r, input logic wd, input chan_t c,
                        input logic [15:0] d, output logic [15:0] q, output logic got);
    @(posedge clk);
    #1;
    sel = 1'b1;
    write = w;
    wide = wd;
    chan = c;
    reg_sel = r;
    wdata = d;
    @(posedge clk);
    #1;
    sel = 1'b0;
    wdata = ~d;
    got = ack;
    q = rdata;
  endtask
endmodule

// File: channel_counter.sv
`timescale 1ns/1ps
`include "timer_status_regs.svh"

module channel_counter (
  input wire logic clk,
  input wire logic rst_n,
  counter_link_if.cnt link
);
  import timer_pkg::*;

  logic next_up;
  logic moving;

  // Down counting is only honoured where the channel allows up/down.
  assign next_up = !(link.updown_ok && link.down_req);
  assign moving = link.step && !link.load && !link.standby;

  // ==========================================================
  // Counter value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.value <= `COUNTER_RESET;
    end else if (link.standby) begin
      link.value <= `COUNTER_RESET;
    end else if (link.load) begin
      link.value <= link.load_value;
    end else if (moving) begin
      link.value <= next_up ? link.value + 16'h0001 : link.value - 16'h0001;
    end
  end

  // ==========================================================
  // Direction, held so software sees the direction of the last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.count_up <= 1'b1;
    end else if (link.standby) begin
      link.count_up <= 1'b1;
    end else begin
      link.count_up <= next_up;
    end
  end

  // ==========================================================
  // Wrap events, one-cycle pulses aligned with the wrapped value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.wrap_up <= 1'b0;
      link.wrap_down <= 1'b0;
    end else begin
      link.wrap_up <= moving && next_up && (link.value == `COUNTER_MAX);
      link.wrap_down <= moving && !next_up && (link.value == `COUNTER_MIN);
    end
  end
endmodule

// File: counter_link_if.sv
`timescale 1ns/1ps

interface counter_link_if;
  import timer_pkg::*;

  logic standby;
  logic load;
  count_t load_value;
  logic step;
  logic updown_ok;
  logic down_req;
  count_t value;
  logic count_up;
  logic wrap_up;
  logic wrap_down;

  modport ctrl (
    output standby,
    output load,
    output load_value,
    output step,
    output updown_ok,
    output down_req,
    input value,
    input count_up,
    input wrap_up,
    input wrap_down
  );

  modport cnt (
    input standby,
    input load,
    input load_value,
    input step,
    input updown_ok,
    input down_req,
    output value,
    output count_up,
    output wrap_up,
    output wrap_down
  );
endinterface

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic CLK, ARST_N, HW_STANDBY, INTERRUPT_DISABLE_SELECT, BUS_SEL, BUS_WRITE;
  logic BUS_WIDE, BUS_REG, BUS_ACK, got;
  logic [15:0] BUS_WDATA, BUS_RDATA, q;
  chan_t BUS_CHAN;
  logic [5:0] COUNT_STEP, COUNT_DOWN, PHASE_MODE, CASCADE_MODE, OVERFLOW_IRQ, UNDERFLOW_IRQ;
  match_bank_t COMPARE_MODE, CAPTURE_STROBE, XFER_START, MATCH_IRQ;
  general_bank_t GENERAL_REGS;
  enable_bank_t IRQ_ENABLE;
  count_bank_t COUNTER_VALUE;
  int n_mismatch = 0;
  int checks = 0;

  timer_status_unit dut_u (.*);
  bus_master_model bm_u (.clk(CLK), .rdata(BUS_RDATA), .ack(BUS_ACK), .sel(BUS_SEL),
    .write(BUS_WRITE), .wide(BUS_WIDE), .chan(BUS_CHAN), .reg_sel(BUS_REG), .wdata(BUS_WDATA));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd(input chan_t c, input logic r);
    bm_u.access(1'b0, r, 1'b1, c, 16'h0000, q, got);
  endtask
  task automatic wr(input chan_t c, input logic r, input logic [15:0] d);
    bm_u.access(1'b1, r, 1'b1, c, d, q, got);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
  // ==========================================================
  // Test sequence
  initial begin
    {ARST_N, HW_STANDBY, INTERRUPT_DISABLE_SELECT} = 3'b000;
    {COUNT_STEP, COUNT_DOWN, PHASE_MODE, CASCADE_MODE} = '0;
    {COMPARE_MODE, CAPTURE_STROBE, XFER_START} = '0;
    GENERAL_REGS = '0;
    IRQ_ENABLE = '0;
    tick(4);
    ARST_N = 1'b1;
    tick(3);
    for (int c = 0; c < 6; c++) begin
      rd(c[2:0], 1'b0);
      chk("status reset", 16'h00C0, q);
      rd(c[2:0], 1'b1);
      chk("counter reset", 16'h0000, q);
    end
    wr(3'd0, 1'b0, 16'h00FF);
    rd(3'd0, 1'b0);
    chk("status ones write", 16'h00C0, q);
    bm_u.access(1'b0, 1'b1, 1'b0, 3'd2, 16'h0000, q, got);
    chk("narrow counter ack", 16'h0000, {15'h0, got});
    wr(3'd2, 1'b1, 16'h1234);
    rd(3'd2, 1'b1);
    chk("counter write", 16'h1234, q);
    HW_STANDBY = 1'b1;
    tick(1);
    HW_STANDBY = 1'b0;
    rd(3'd2, 1'b1);
    chk("counter standby", 16'h0000, q);
    wr(3'd0, 1'b1, 16'hFFFE);
    IRQ_ENABLE[0] = 8'h10;
    COUNT_STEP = 6'b000001;
    tick(2);
    COUNT_STEP = '0;
    tick(2);
    chk("overflow irq", 16'h0001, {15'h0, OVERFLOW_IRQ[0]});
    IRQ_ENABLE[0] = 8'h00;
    tick(1);
    chk("overflow irq masked", 16'h0000, {15'h0, OVERFLOW_IRQ[0]});
    wr(3'd0, 1'b0, 16'h0000);
    rd(3'd0, 1'b0);
    chk("overflow set", 16'h00D0, q);
    wr(3'd0, 1'b0, 16'h0000);
    rd(3'd0, 1'b0);
    chk("overflow clear", 16'h00C0, q);
    IRQ_ENABLE[1] = 8'h20;
    PHASE_MODE = 6'b001010;
    CASCADE_MODE = 6'b000100;
    COUNT_DOWN = 6'b001110;
    COUNT_STEP = 6'b001110;
    tick(1);
    COUNT_STEP = '0;
    tick(2);
    chk("underflow irq", 16'h0001, {15'h0, UNDERFLOW_IRQ[1]});
    rd(3'd1, 1'b1);
    chk("down count", 16'hFFFF, q);
    rd(3'd3, 1'b1);
    chk("up only channel", 16'h0001, q);
    rd(3'd2, 1'b1);
    chk("cascade down count", 16'hFFFF, q);
    rd(3'd2, 1'b0);
    chk("cascade no underflow", 16'h0040, q);
    rd(3'd1, 1'b0);
    chk("underflow and direction", 16'h0060, q);
    wr(3'd1, 1'b0, 16'h0000);
    rd(3'd1, 1'b0);
    chk("underflow clear", 16'h0040, q);
    COUNT_DOWN = '0;
    CASCADE_MODE = '0;
    tick(2);
    rd(3'd1, 1'b0);
    chk("direction up", 16'h00C0, q);
    IRQ_ENABLE[3] = 8'h08;
    GENERAL_REGS[3][3] = 16'h0005;
    COMPARE_MODE[3][3] = 1'b1;
    wr(3'd3, 1'b1, 16'h0004);
    COUNT_STEP[3] = 1'b1;
    tick(1);
    COUNT_STEP = '0;
    tick(2);
    chk("match irq d", 16'h0008, {12'h0, MATCH_IRQ[3]});
    rd(3'd3, 1'b0);
    chk("compare flag", 16'h00C8, q);
    XFER_START[3][3] = 1'b1;
    tick(1);
    XFER_START = '0;
    rd(3'd3, 1'b0);
    chk("transfer clear", 16'h00C0, q);
    CAPTURE_STROBE[1] = 4'b0110;
    tick(1);
    CAPTURE_STROBE = '0;
    INTERRUPT_DISABLE_SELECT = 1'b1;
    XFER_START[1][1] = 1'b1;
    tick(1);
    XFER_START = '0;
    rd(3'd1, 1'b0);
    chk("capture flag", 16'h00C2, q);
    wr(3'd1, 1'b0, 16'h0000);
    rd(3'd1, 1'b0);
    chk("capture clear", 16'h00C0, q);
    give_verdict;
  end
endmodule

// File: timer_pkg.sv
package timer_pkg;

  typedef logic [15:0] count_t;
  typedef logic [7:0] status_t;
  typedef logic [2:0] chan_t;
  typedef logic [3:0] match_t;
  typedef match_t [5:0] match_bank_t;
  typedef status_t [5:0] enable_bank_t;
  typedef count_t [5:0] count_bank_t;
  typedef count_t [3:0] general_set_t;
  typedef general_set_t [5:0] general_bank_t;

  typedef enum {
    OP_NONE,
    OP_READ_STATUS,
    OP_WRITE_STATUS,
    OP_READ_COUNTER,
    OP_WRITE_COUNTER,
    OP_REFUSED
  } bus_op_t;

endpackage

// File: timer_status_regs.svh
`ifndef TIMER_STATUS_REGS_SVH
`define TIMER_STATUS_REGS_SVH

// ==========================================================
// Sizes and reset values
`define CHANNEL_COUNT 6
`define STATUS_RESET 8'hC0
`define COUNTER_RESET 16'h0000
`define COUNTER_MAX 16'hFFFF
`define COUNTER_MIN 16'h0000

// ==========================================================
// Status register bit positions
`define BIT_DIRECTION 7
`define BIT_RESERVED_ONE 6
`define BIT_UNDERFLOW 5
`define BIT_OVERFLOW 4
`define BIT_MATCH_D 3
`define BIT_MATCH_C 2
`define BIT_MATCH_B 1
`define BIT_MATCH_A 0

// ==========================================================
// Register select on the access port, and the four-flag channels
`define SELECT_STATUS 1'b0
`define SELECT_COUNTER 1'b1
`define FOUR_FLAG_CHAN_LO 0
`define FOUR_FLAG_CHAN_HI 3
`define MASK_FOUR_FLAGS 4'hF
`define MASK_TWO_FLAGS 4'h3

`endif

// File: timer_status_sva.sv
`timescale 1ns/1ps
module timer_status_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HW_STANDBY,
  input wire logic BUS_SEL,
  input wire logic BUS_WRITE,
  input wire logic BUS_WIDE,
  input wire timer_pkg::chan_t BUS_CHAN,
  input wire logic BUS_REG,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_ACK,
  input wire logic [5:0] PHASE_MODE,
  input wire timer_pkg::general_bank_t GENERAL_REGS,
  input wire timer_pkg::match_bank_t CAPTURE_STROBE,
  input wire timer_pkg::match_bank_t XFER_START,
  input wire logic INTERRUPT_DISABLE_SELECT,
  input wire timer_pkg::enable_bank_t IRQ_ENABLE,
  input wire timer_pkg::count_bank_t COUNTER_VALUE,
  input wire timer_pkg::match_bank_t MATCH_IRQ,
  input wire logic [5:0] OVERFLOW_IRQ,
  input wire logic [5:0] UNDERFLOW_IRQ
);
  import timer_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  // ==========================================================
  // Status read seen in the answer cycle
  logic rd_st;
  chan_t rd_ch;
  logic ch03;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_st <= 1'b0;
      rd_ch <= '0;
    end else begin
      rd_st <= BUS_SEL && !BUS_WRITE && !BUS_REG && BUS_CHAN < 3'h6;
      rd_ch <= BUS_CHAN;
    end
  end
  assign ch03 = rd_ch == 3'h0 || rd_ch == 3'h3;
  // ==========================================================
  // Checks
  AST_RES_ONE: assert property (rd_st |-> BUS_ACK && BUS_RDATA[6])
    else $error("reserved bit 6 not read as one");
  AST_RES_DIR: assert property (rd_st && ch03 |-> BUS_RDATA[7])
    else $error("bit 7 of channel 0 or 3 not one");
  AST_RES_UNF: assert property (rd_st && ch03 |-> !BUS_RDATA[5])
    else $error("bit 5 of channel 0 or 3 not zero");
  AST_NO_CD: assert property (rd_st && !ch03 |-> BUS_RDATA[3:2] == 2'b00)
    else $error("flags C or D seen in a two-flag channel");
  AST_NARROW: assert property (BUS_SEL && BUS_REG && !BUS_WIDE |=> !BUS_ACK)
    else $error("narrow counter access answered");
  AST_STBY: assert property (HW_STANDBY |=> COUNTER_VALUE == '0)
    else $error("counter not cleared in standby");
  AST_OVF: assert property (!HW_STANDBY && $past(COUNTER_VALUE[0]) == 16'hFFFF
    && COUNTER_VALUE[0] == 16'h0000 && IRQ_ENABLE[0][4] |=> OVERFLOW_IRQ[0])
    else $error("overflow not flagged");
  AST_OVF_EN: assert property (OVERFLOW_IRQ[0] |-> IRQ_ENABLE[0][4])
    else $error("overflow request while disabled");
  AST_UNF: assert property (!HW_STANDBY && $past(PHASE_MODE[1]) && IRQ_ENABLE[1][5]
    && $past(COUNTER_VALUE[1]) == 16'h0000 && COUNTER_VALUE[1] == 16'hFFFF
    |=> UNDERFLOW_IRQ[1])
    else $error("underflow not flagged");
  AST_DTC_CLR: assert property (XFER_START[3][3] && !INTERRUPT_DISABLE_SELECT
    && !CAPTURE_STROBE[3][3] && $stable(COUNTER_VALUE[3]) && $stable(GENERAL_REGS[3][3])
    |=> !MATCH_IRQ[3][3])
    else $error("transfer start did not clear flag D");
  cover property (rd_st);
  cover property (OVERFLOW_IRQ[0]);
  cover property (HW_STANDBY);
endmodule

bind timer_status_unit timer_status_sva chk_u (.*);

// File: timer_status_unit.sv
`timescale 1ns/1ps
`include "timer_status_regs.svh"

module timer_status_unit (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HW_STANDBY,
  input wire logic BUS_SEL,
  input wire logic BUS_WRITE,
  input wire logic BUS_WIDE,
  input wire timer_pkg::chan_t BUS_CHAN,
  input wire logic BUS_REG,
  input wire logic [15:0] BUS_WDATA,
  output logic [15:0] BUS_RDATA,
  output logic BUS_ACK,
  input wire logic [5:0] COUNT_STEP,
  input wire logic [5:0] COUNT_DOWN,
  input wire logic [5:0] PHASE_MODE,
  input wire logic [5:0] CASCADE_MODE,
  input wire timer_pkg::match_bank_t COMPARE_MODE,
  input wire timer_pkg::general_bank_t GENERAL_REGS,
  input wire timer_pkg::match_bank_t CAPTURE_STROBE,
  input wire timer_pkg::match_bank_t XFER_START,
  input wire logic INTERRUPT_DISABLE_SELECT,
  input wire timer_pkg::enable_bank_t IRQ_ENABLE,
  output timer_pkg::count_bank_t COUNTER_VALUE,
  output timer_pkg::match_bank_t MATCH_IRQ,
  output logic [5:0] OVERFLOW_IRQ,
  output logic [5:0] UNDERFLOW_IRQ
);
  import timer_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic flag_next(input logic flag, input logic set, input logic clr);
    // A set arriving with a clear wins, so no event is ever lost.
    return set | (flag & ~clr);
  endfunction

  function automatic logic four_flag_chan(input int ch);
    return (ch == `FOUR_FLAG_CHAN_LO) || (ch == `FOUR_FLAG_CHAN_HI);
  endfunction

  function automatic bus_op_t decode_op(input logic sel, input logic wr, input logic wide,
                                        input logic reg_sel, input chan_t ch);
    bus_op_t op;
    op = OP_NONE;
    if (sel) begin
      if (ch >= chan_t'(`CHANNEL_COUNT)) begin
        op = OP_REFUSED;
      end else if (reg_sel == `SELECT_STATUS) begin
        op = wr ? OP_WRITE_STATUS : OP_READ_STATUS;
      end else if (!wide) begin
        // Byte access to a counter would split the word, so it is refused.
        op = OP_REFUSED;
      end else begin
        op = wr ? OP_WRITE_COUNTER : OP_READ_COUNTER;
      end
    end
    return op;
  endfunction

  function automatic status_t status_image(input logic four, input logic dir,
                                           input logic unf, input logic ovf,
                                           input match_t m);
    status_t img;
    img = 8'h00;
    img[`BIT_RESERVED_ONE] = 1'b1;
    img[`BIT_DIRECTION] = four ? 1'b1 : dir;
    img[`BIT_UNDERFLOW] = four ? 1'b0 : unf;
    img[`BIT_OVERFLOW] = ovf;
    img[`BIT_MATCH_D] = four ? m[3] : 1'b0;
    img[`BIT_MATCH_C] = four ? m[2] : 1'b0;
    img[`BIT_MATCH_B] = m[1];
    img[`BIT_MATCH_A] = m[0];
    return img;
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // Access decode
  bus_op_t op;
  status_t image [`CHANNEL_COUNT];
  count_t count_now [`CHANNEL_COUNT];

  assign op = decode_op(BUS_SEL, BUS_WRITE, BUS_WIDE, BUS_REG, BUS_CHAN);

  // Read data and acknowledge appear one cycle after the request.
  always_ff @(posedge CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      BUS_RDATA <= 16'h0000;
      BUS_ACK <= 1'b0;
    end else begin
      BUS_ACK <= (op != OP_NONE) && (op != OP_REFUSED);
      unique case (op)
        OP_READ_STATUS: begin
          BUS_RDATA <= {8'h00, image[BUS_CHAN]};
        end
        OP_READ_COUNTER: begin
          BUS_RDATA <= count_now[BUS_CHAN];
        end
        OP_NONE, OP_WRITE_STATUS, OP_WRITE_COUNTER, OP_REFUSED: begin
          BUS_RDATA <= BUS_RDATA;
        end
      endcase
    end
  end

  // ==========================================================
  // Per-channel counters and status flags
  counter_link_if link [`CHANNEL_COUNT] ();

  genvar g;
  generate
    for (g = 0; g < `CHANNEL_COUNT; g++) begin : chan
      localparam logic FOUR = four_flag_chan(g);
      localparam match_t MASK = FOUR ? `MASK_FOUR_FLAGS : `MASK_TWO_FLAGS;

      logic hit_rd;
      logic hit_wr;
      logic ovf;
      logic unf;
      match_t match;
      logic ovf_armed;
      logic unf_armed;
      match_t match_armed;
      match_t cmp_level;
      match_t cmp_prev;
      match_t match_set;
      match_t match_clr;
      logic ovf_clr;
      logic unf_clr;

      assign hit_rd = (op == OP_READ_STATUS) && (BUS_CHAN == chan_t'(g));
      assign hit_wr = (op == OP_WRITE_STATUS) && (BUS_CHAN == chan_t'(g));

      // Counter for this channel; each channel has its own instance.
      assign link[g].standby = HW_STANDBY;
      assign link[g].load = (op == OP_WRITE_COUNTER) && (BUS_CHAN == chan_t'(g));
      assign link[g].load_value = BUS_WDATA;
      assign link[g].step = COUNT_STEP[g];
      assign link[g].updown_ok = !FOUR && (PHASE_MODE[g] || CASCADE_MODE[g]);
      assign link[g].down_req = COUNT_DOWN[g];
      assign count_now[g] = link[g].value;
      assign COUNTER_VALUE[g] = link[g].value;

      channel_counter u_counter (
        .clk(CLK),
        .rst_n(rst_sync),
        .link(link[g])
      );

      // Compare match is taken on the cycle equality begins, so a counter
      // parked on the compare value does not keep re-setting the flag.
      always_comb begin
        for (int k = 0; k < 4; k++) begin
          cmp_level[k] = COMPARE_MODE[g][k] && (link[g].value == GENERAL_REGS[g][k]);
        end
      end

      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          cmp_prev <= 4'h0;
        end else begin
          cmp_prev <= cmp_level;
        end
      end

      assign match_set = MASK & ~{4{HW_STANDBY}} &
                         ((cmp_level & ~cmp_prev) |
                          (CAPTURE_STROBE[g] & ~COMPARE_MODE[g]));

      // A zero written to an armed flag clears it; a one is ignored.
      assign match_clr = (XFER_START[g] & {4{!INTERRUPT_DISABLE_SELECT}}) |
                         ({4{hit_wr}} & ~BUS_WDATA[3:0] & match_armed);
      assign ovf_clr = hit_wr && !BUS_WDATA[`BIT_OVERFLOW] && ovf_armed;
      assign unf_clr = hit_wr && !BUS_WDATA[`BIT_UNDERFLOW] && unf_armed;

      // ==========================================================
      // Overflow flag
      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          ovf <= 1'b0;
        end else if (HW_STANDBY) begin
          ovf <= 1'b0;
        end else begin
          ovf <= flag_next(ovf, link[g].wrap_up, ovf_clr);
        end
      end

      // ==========================================================
      // Underflow flag, only ever set in the up/down channels
      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          unf <= 1'b0;
        end else if (HW_STANDBY) begin
          unf <= 1'b0;
        end else begin
          unf <= flag_next(unf, !FOUR && PHASE_MODE[g] && link[g].wrap_down, unf_clr);
        end
      end

      // ==========================================================
      // Match flags, masked so absent flags can never be set
      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          match <= 4'h0;
        end else if (HW_STANDBY) begin
          match <= 4'h0;
        end else begin
          for (int k = 0; k < 4; k++) begin
            match[k] <= MASK[k] & flag_next(match[k], match_set[k], match_clr[k]);
          end
        end
      end

      // ==========================================================
      // Read-as-one history. A set that survives a clear attempt needs a
      // fresh read before the next zero write will take effect.
      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          ovf_armed <= 1'b0;
        end else if (HW_STANDBY || hit_wr) begin
          ovf_armed <= 1'b0;
        end else if (hit_rd) begin
          ovf_armed <= ovf_armed | ovf;
        end
      end

      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          unf_armed <= 1'b0;
        end else if (HW_STANDBY || hit_wr) begin
          unf_armed <= 1'b0;
        end else if (hit_rd) begin
          unf_armed <= unf_armed | (unf & !FOUR);
        end
      end

      always_ff @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
          match_armed <= 4'h0;
        end else if (HW_STANDBY || hit_wr) begin
          match_armed <= 4'h0;
        end else if (hit_rd) begin
          match_armed <= match_armed | (match & MASK);
        end
      end

      assign image[g] = status_image(FOUR, link[g].count_up, unf, ovf, match);

      // Interrupt requests gated by the enable byte.
      assign OVERFLOW_IRQ[g] = ovf && IRQ_ENABLE[g][`BIT_OVERFLOW];
      assign UNDERFLOW_IRQ[g] = unf && IRQ_ENABLE[g][`BIT_UNDERFLOW] && !FOUR;
      assign MATCH_IRQ[g] = match & IRQ_ENABLE[g][3:0] & MASK;
    end
  endgenerate
endmodule
